// [core/dmsd_decoder.sv]
// Data memory space decoder: sorts core data accesses into internal RAM,
// special register space, expanded on-chip RAM and the external bus.
// Assumes requests come from core logic on clk_sys_in; the muxed port input
// comes from pins and is synchronised here.
// Function
// - Lower RAM 00H-7FH reachable by direct and indirect modes.
// - Upper RAM 80H-FFH reachable by indirect modes only.
// - Special register space 80H-FFH reachable by direct mode only.
// - Above 7FH, direct goes to special space, indirect to upper RAM.
// - Expanded RAM 256 or 768 bytes at lowest external addresses, select clear.
// - Select clear: index and pointer external moves hit expanded RAM in range.
// - Expanded RAM access leaves muxed port and strobes idle.
// - High-address port shows its register contents, even for expanded RAM.
// - Select clear, pointer moves above range run a full external cycle.
// - Select set, index moves give 8-bit address on the muxed port.
// - Select set, pointer moves give high byte on high port, low muxed.
// - Active-low write strobe for writes, read strobe for reads.
// - Stack accesses reach only internal 256-byte RAM, never expanded RAM.
`timescale 1ns/1ps
module dmsd_decoder
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic req_valid_in,
	input wire dmsd_pkg::dmsd_mode_t req_mode_in,
	input wire logic [15:0] req_addr_in,
	input wire logic req_write_in,
	input wire logic [7:0] req_wdata_in,
	input wire logic ext_data_select_bit_in,
	input wire logic large_variant_in,
	input wire logic [7:0] high_address_port_reg_in,
	input wire logic [7:0] muxed_address_data_port_in,
	output logic req_ready_out,
	output logic resp_valid_out,
	output logic [7:0] resp_rdata_out,
	output dmsd_pkg::dmsd_region_t region_out,
	output logic [7:0] internal_addr_out,
	output logic internal_write_out,
	output logic [7:0] internal_wdata_out,
	output logic [7:0] muxed_address_data_port_out,
	output logic muxed_address_data_port_oe_out,
	output logic [7:0] high_address_port_out,
	output logic addr_latch_enable_out,
	output logic write_strobe_n_out,
	output logic read_strobe_n_out
);
	import dmsd_pkg::*;

	// ------------------------------------------------------------------
	// Region decode
	// ------------------------------------------------------------------
	// Shared by the request path and the checks below
	function automatic dmsd_region_t dmsd_decode(dmsd_mode_t mode, logic [15:0] addr,
		logic xsel, logic big);
		logic [15:0] top;
		top = big ? DMSD_EXPANDED_ON_CHIP_RAM_TOP_LARGE : DMSD_EXPANDED_ON_CHIP_RAM_TOP_SMALL;
		case (mode)
			DMSD_MODE_DIRECT:
				dmsd_decode = (addr[7:0] <= DMSD_LOWER_TOP) ? DMSD_REG_LOWER : DMSD_REG_SPECIAL;
			DMSD_MODE_INDIRECT, DMSD_MODE_STACK:
				dmsd_decode = (addr[7:0] <= DMSD_LOWER_TOP) ? DMSD_REG_LOWER : DMSD_REG_UPPER;
			DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_RI:
				dmsd_decode = xsel ? DMSD_REG_EXT : DMSD_REG_EXPANDED_ON_CHIP_RAM;
			DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR:
				dmsd_decode = (!xsel && addr <= top) ? DMSD_REG_EXPANDED_ON_CHIP_RAM : DMSD_REG_EXT;
			default:
				dmsd_decode = DMSD_REG_NONE;
		endcase
	endfunction : dmsd_decode

	dmsd_state_t state_q;
	logic ready_q;
	logic resp_valid_q;
	logic [7:0] resp_rdata_q;
	dmsd_region_t region_q;
	logic [7:0] iaddr_q;
	logic iwrite_q;
	logic [7:0] iwdata_q;
	logic [7:0] p0_q;
	logic p0_oe_q;
	logic [7:0] p2_q;
	logic ale_q;
	logic wr_n_q;
	logic rd_n_q;
	logic [2:0] cnt_q;
	logic xwrite_q;
	logic [7:0] xwdata_q;
	logic [7:0] p0_sync1_q;
	logic [7:0] p0_sync2_q;

	wire accept = req_valid_in && ready_q;
	wire dmsd_region_t req_region = dmsd_decode(req_mode_in, req_addr_in, ext_data_select_bit_in,
		large_variant_in);
	wire to_internal = (req_region == DMSD_REG_LOWER) || (req_region == DMSD_REG_UPPER)
		|| (req_region == DMSD_REG_SPECIAL);
	// Index moves carry only the low address byte
	wire [15:0] eff_addr = (req_mode_in == DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_RI) ? {8'h00, req_addr_in[7:0]} : req_addr_in;
	// Pointer moves with external target put the pointer high byte out
	wire [7:0] ext_high = (req_mode_in == DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR) ? req_addr_in[15:8]
		: high_address_port_reg_in;
	wire strobe_done = (cnt_q == DMSD_CNT_ZERO);

	dmsd_expanded_on_chip_ram_if expanded_on_chip_ram_bus ();

	// ------------------------------------------------------------------
	// Expanded RAM port
	// ------------------------------------------------------------------
	// Driven straight from the request so the answer comes two cycles after acceptance
	assign expanded_on_chip_ram_bus.en = accept && (req_region == DMSD_REG_EXPANDED_ON_CHIP_RAM);
	assign expanded_on_chip_ram_bus.we = req_write_in;
	assign expanded_on_chip_ram_bus.addr = eff_addr[DMSD_EXPANDED_ON_CHIP_RAM_AW-1:0];
	assign expanded_on_chip_ram_bus.wdata = req_wdata_in;

	dmsd_expanded_on_chip_ram u_expanded_on_chip_ram
	(
		.clk_sys_in (clk_sys_in),
		.rst_in (rst_in),
		.bus (expanded_on_chip_ram_bus)
	);

	// ------------------------------------------------------------------
	// Pin input synchroniser
	// ------------------------------------------------------------------
	// Read data comes from an unrelated driver, so two stages first
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			p0_sync1_q <= 8'h00;
			p0_sync2_q <= 8'h00;
		end
		else
		begin
			p0_sync1_q <= muxed_address_data_port_in;
			p0_sync2_q <= p0_sync1_q;
		end
	end

	// ------------------------------------------------------------------
	// Internal target pulse
	// ------------------------------------------------------------------
	// One-cycle region pulse with address for internal RAM and special space
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			region_q <= DMSD_REG_NONE;
			iaddr_q <= 8'h00;
			iwrite_q <= 1'b0;
			iwdata_q <= 8'h00;
		end
		else
		begin
			region_q <= accept ? req_region : DMSD_REG_NONE;
			iaddr_q <= req_addr_in[7:0];
			iwrite_q <= accept && to_internal && req_write_in;
			iwdata_q <= req_wdata_in;
		end
	end

	// ------------------------------------------------------------------
	// Bus cycle sequencer
	// ------------------------------------------------------------------
	// Address phase with latch enable, a hold cycle, then a fixed strobe.
	// Read data is taken at the last strobe cycle from the synchronised
	// port, so the memory must settle within the first two strobe cycles.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_q <= DMSD_ST_IDLE;
			ready_q <= 1'b0;
			resp_valid_q <= 1'b0;
			resp_rdata_q <= 8'h00;
			p0_q <= 8'h00;
			p0_oe_q <= 1'b0;
			p2_q <= 8'h00;
			ale_q <= 1'b0;
			wr_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			cnt_q <= DMSD_CNT_ZERO;
			xwrite_q <= 1'b0;
			xwdata_q <= 8'h00;
		end
		else
		begin
			resp_valid_q <= 1'b0;
			case (state_q)
				DMSD_ST_IDLE:
				begin
					ready_q <= 1'b1;
					p2_q <= high_address_port_reg_in;
					if (accept && req_region == DMSD_REG_EXPANDED_ON_CHIP_RAM)
					begin
						ready_q <= 1'b0;
						state_q <= DMSD_ST_EXPANDED_ON_CHIP_RAM;
					end
					else if (accept && req_region == DMSD_REG_EXT)
					begin
						ready_q <= 1'b0;
						p2_q <= ext_high;
						p0_q <= eff_addr[7:0];
						p0_oe_q <= 1'b1;
						ale_q <= 1'b1;
						xwrite_q <= req_write_in;
						xwdata_q <= req_wdata_in;
						state_q <= DMSD_ST_ADDR;
					end
				end
				DMSD_ST_EXPANDED_ON_CHIP_RAM:
				begin
					// Port pins untouched, only the answer is given
					resp_valid_q <= 1'b1;
					resp_rdata_q <= expanded_on_chip_ram_bus.rdata;
					ready_q <= 1'b1;
					state_q <= DMSD_ST_IDLE;
				end
				DMSD_ST_ADDR:
				begin
					ale_q <= 1'b0;
					state_q <= DMSD_ST_LATCH;
				end
				DMSD_ST_LATCH:
				begin
					// Address held one cycle past the latch edge
					p0_q <= xwdata_q;
					p0_oe_q <= xwrite_q;
					wr_n_q <= !xwrite_q;
					rd_n_q <= xwrite_q;
					cnt_q <= DMSD_STROBE_CYCLES - DMSD_CNT_ONE;
					state_q <= DMSD_ST_STROBE;
				end
				DMSD_ST_STROBE:
				begin
					if (strobe_done)
					begin
						wr_n_q <= 1'b1;
						rd_n_q <= 1'b1;
						p0_oe_q <= 1'b0;
						resp_valid_q <= 1'b1;
						resp_rdata_q <= xwrite_q ? 8'h00 : p0_sync2_q;
						ready_q <= 1'b1;
						state_q <= DMSD_ST_IDLE;
					end
					else
						cnt_q <= cnt_q - DMSD_CNT_ONE;
				end
				default:
					state_q <= DMSD_ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign req_ready_out = ready_q;
	assign resp_valid_out = resp_valid_q;
	assign resp_rdata_out = resp_rdata_q;
	assign region_out = region_q;
	assign internal_addr_out = iaddr_q;
	assign internal_write_out = iwrite_q;
	assign internal_wdata_out = iwdata_q;
	assign muxed_address_data_port_out = p0_q;
	assign muxed_address_data_port_oe_out = p0_oe_q;
	assign high_address_port_out = p2_q;
	assign addr_latch_enable_out = ale_q;
	assign write_strobe_n_out = wr_n_q;
	assign read_strobe_n_out = rd_n_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	lower_map_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		accept && (req_mode_in == DMSD_MODE_DIRECT || req_mode_in == DMSD_MODE_INDIRECT)
		&& req_addr_in[7:0] <= DMSD_LOWER_TOP |=> region_q == DMSD_REG_LOWER)
		else $error("lower RAM access not routed to lower RAM");

	upper_indirect_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		accept && req_mode_in == DMSD_MODE_INDIRECT && req_addr_in[7:0] > DMSD_LOWER_TOP
		|=> region_q == DMSD_REG_UPPER && iaddr_q == $past(req_addr_in[7:0]))
		else $error("indirect high access not routed to upper RAM");

	special_direct_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		accept && req_mode_in == DMSD_MODE_DIRECT && req_addr_in[7:0] > DMSD_LOWER_TOP
		|=> region_q == DMSD_REG_SPECIAL)
		else $error("direct high access not routed to special space");

	expanded_on_chip_ram_select_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		accept && dmsd_decode(req_mode_in, req_addr_in, ext_data_select_bit_in, large_variant_in)
		== DMSD_REG_EXPANDED_ON_CHIP_RAM |=> state_q == DMSD_ST_EXPANDED_ON_CHIP_RAM ##1 resp_valid_q && ready_q)
		else $error("expanded RAM access did not answer in two cycles");

	expanded_on_chip_ram_quiet_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		state_q == DMSD_ST_EXPANDED_ON_CHIP_RAM |-> wr_n_q && rd_n_q && !p0_oe_q && !ale_q)
		else $error("expanded RAM access disturbed the external bus");

	high_port_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		state_q == DMSD_ST_IDLE && !(accept && req_region == DMSD_REG_EXT)
		|=> p2_q == $past(high_address_port_reg_in))
		else $error("high-address port not showing its register");

	ptr_ext_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		accept && req_mode_in == DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR && req_region == DMSD_REG_EXT
		|=> ale_q && p0_oe_q && p2_q == $past(req_addr_in[15:8]) && p0_q == $past(req_addr_in[7:0]))
		else $error("pointer move did not present a 16-bit address");

	index_ext_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		accept && req_mode_in == DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_RI && ext_data_select_bit_in
		|=> ale_q && p0_q == $past(req_addr_in[7:0]) && p2_q == $past(high_address_port_reg_in))
		else $error("index move did not present an 8-bit address");

	read_strobe_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		$fell(rd_n_q) |-> wr_n_q throughout ((!rd_n_q)[*4] ##1 (rd_n_q && resp_valid_q)))
		else $error("read strobe width or write strobe wrong");

	write_strobe_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		$fell(wr_n_q) |-> (!wr_n_q && rd_n_q && p0_oe_q)[*4] ##1 wr_n_q)
		else $error("write strobe width or data drive wrong");

	stack_internal_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		accept && req_mode_in == DMSD_MODE_STACK
		|=> (region_q == DMSD_REG_LOWER || region_q == DMSD_REG_UPPER) && state_q == DMSD_ST_IDLE)
		else $error("stack access left internal RAM");
endmodule : dmsd_decoder

// [core/dmsd_pkg.sv]
// Constants and types shared by the data memory space decoder and its
// expanded RAM store.
// Assumes a single 250 MHz core clock domain.
package dmsd_pkg;

	// ------------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------------
	localparam logic [7:0] DMSD_LOWER_TOP = 8'h7F;
	localparam logic [15:0] DMSD_EXPANDED_ON_CHIP_RAM_TOP_SMALL = 16'h00FF;
	localparam logic [15:0] DMSD_EXPANDED_ON_CHIP_RAM_TOP_LARGE = 16'h02FF;
	localparam int DMSD_EXPANDED_ON_CHIP_RAM_DEPTH = 768;
	localparam int DMSD_EXPANDED_ON_CHIP_RAM_AW = 10;

	// ------------------------------------------------------------------
	// External bus timing, in core clock cycles
	// ------------------------------------------------------------------
	localparam logic [2:0] DMSD_STROBE_CYCLES = 3'h4;
	localparam logic [2:0] DMSD_CNT_ONE = 3'h1;
	localparam logic [2:0] DMSD_CNT_ZERO = 3'h0;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		DMSD_MODE_DIRECT = 3'h0,
		DMSD_MODE_INDIRECT = 3'h1,
		DMSD_MODE_STACK = 3'h2,
		DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_RI = 3'h3,
		DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR = 3'h4
	} dmsd_mode_t;

	typedef enum logic [4:0]
	{
		DMSD_REG_NONE = 5'h00,
		DMSD_REG_LOWER = 5'h01,
		DMSD_REG_UPPER = 5'h02,
		DMSD_REG_SPECIAL = 5'h04,
		DMSD_REG_EXPANDED_ON_CHIP_RAM = 5'h08,
		DMSD_REG_EXT = 5'h10
	} dmsd_region_t;

	typedef enum logic [4:0]
	{
		DMSD_ST_IDLE = 5'h01,
		DMSD_ST_EXPANDED_ON_CHIP_RAM = 5'h02,
		DMSD_ST_ADDR = 5'h04,
		DMSD_ST_LATCH = 5'h08,
		DMSD_ST_STROBE = 5'h10
	} dmsd_state_t;

endpackage : dmsd_pkg

// [core/dmsd_expanded_on_chip_ram_if.sv]
// Port bundle between the decoder and its on-chip expanded RAM store.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
interface dmsd_expanded_on_chip_ram_if;
	logic en;
	logic we;
	logic [dmsd_pkg::DMSD_EXPANDED_ON_CHIP_RAM_AW-1:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport user (output en, output we, output addr, output wdata, input rdata);
	modport store (input en, input we, input addr, input wdata, output rdata);
endinterface : dmsd_expanded_on_chip_ram_if

// [core/dmsd_expanded_on_chip_ram.sv]
// Flip-flop store for the on-chip expanded data RAM.
// Assumes the decoder only enables it for addresses inside the array.
`timescale 1ns/1ps
module dmsd_expanded_on_chip_ram
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	dmsd_expanded_on_chip_ram_if.store bus
);
	import dmsd_pkg::*;

	logic [7:0] mem_q [0:DMSD_EXPANDED_ON_CHIP_RAM_DEPTH-1];
	logic [7:0] rdata_q;

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	// Data cells carry no reset, only the read register does
	always_ff @(posedge clk_sys_in)
	begin
		if (bus.en && bus.we)
			mem_q[bus.addr] <= bus.wdata;
	end

	// Read data valid one cycle after the enable
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			rdata_q <= 8'h00;
		else if (bus.en)
			rdata_q <= mem_q[bus.addr];
	end

	assign bus.rdata = rdata_q;
endmodule : dmsd_expanded_on_chip_ram

// [verification/dmsd_ext_mem.sv]
// External data memory model on the muxed address/data bus.
// Assumes the decoder drives ALE, strobes and ports on clk_sys_in.
`timescale 1ns/1ps
module dmsd_ext_mem
(
	input wire logic clk_sys_in,
	input wire logic [7:0] muxed_in,
	input wire logic oe_in,
	input wire logic ale_in,
	input wire logic [7:0] high_port_in,
	input wire logic wr_n_in,
	input wire logic rd_n_in,
	output logic [7:0] muxed_out
);
	logic [7:0] mem_q [logic [15:0]];
	logic [15:0] addr_q;

	// ---------------------------------------------------------------
	// Latch address, store writes, answer reads
	// ---------------------------------------------------------------
	initial muxed_out = 8'h00;
	// Released bus shows a toggling pattern, so a stale byte never passes
	always @(posedge clk_sys_in)
	begin
		if (ale_in)
			addr_q = {high_port_in, muxed_in};
		if (!wr_n_in && oe_in)
			mem_q[addr_q] = muxed_in;
		if (!rd_n_in)
			muxed_out <= mem_q.exists(addr_q) ? mem_q[addr_q] : 8'h00;
		else if (oe_in)
			muxed_out <= muxed_in;
		else
			muxed_out <= ~muxed_out;
	end
endmodule : dmsd_ext_mem

// [verification/testbench.sv]
// Self-checking bench for the data memory space decoder.
// Assumes the external memory model answers on the muxed port.
`timescale 1ns/1ps
module testbench;
	import dmsd_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic req_valid_in = 1'b0;
	dmsd_mode_t req_mode_in = DMSD_MODE_DIRECT;
	logic [15:0] req_addr_in = 16'h0000;
	logic req_write_in = 1'b0;
	logic [7:0] req_wdata_in = 8'h00;
	logic sel_bit = 1'b0;
	logic large_var = 1'b0;
	logic [7:0] hp_reg = 8'hC3;
	logic [7:0] mux_in, mux_out, hp_out, rdata;
	logic oe, ale, wr_n, rd_n, ready, resp_valid, int_wr;
	logic [7:0] int_addr, int_wdata;
	dmsd_region_t region, got_region;
	logic [7:0] got_rdata, hp_ale, n_wr, n_rd, n_oe;
	int n_errors = 0;
	int total_checks = 0;

	always #2 clk_sys_in = ~clk_sys_in;

	dmsd_decoder dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
		.req_mode_in(req_mode_in), .req_addr_in(req_addr_in), .req_write_in(req_write_in),
		.req_wdata_in(req_wdata_in), .ext_data_select_bit_in(sel_bit), .large_variant_in(large_var),
		.high_address_port_reg_in(hp_reg), .muxed_address_data_port_in(mux_in),
		.req_ready_out(ready), .resp_valid_out(resp_valid), .resp_rdata_out(rdata),
		.region_out(region), .internal_addr_out(int_addr), .internal_write_out(int_wr),
		.internal_wdata_out(int_wdata), .muxed_address_data_port_out(mux_out),
		.muxed_address_data_port_oe_out(oe), .high_address_port_out(hp_out),
		.addr_latch_enable_out(ale), .write_strobe_n_out(wr_n), .read_strobe_n_out(rd_n));

	dmsd_ext_mem mem_u (.clk_sys_in(clk_sys_in), .muxed_in(mux_out), .oe_in(oe), .ale_in(ale),
		.high_port_in(hp_out), .wr_n_in(wr_n), .rd_n_in(rd_n), .muxed_out(mux_in));

	// ---------------------------------------------------------------
	// Pin activity monitor
	// ---------------------------------------------------------------
	always @(posedge clk_sys_in)
	begin
		if (wr_n === 1'b0) n_wr++;
		if (rd_n === 1'b0) n_rd++;
		if (oe === 1'b1) n_oe++;
		if (ale === 1'b1) hp_ale = hp_out;
	end

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_region(input dmsd_region_t got, input dmsd_region_t exp);
		chk_byte({3'h0, got}, {3'h0, exp});
	endtask : chk_region

	// One request at the falling edge; waits for the answer if one is due
	task automatic do_req(input dmsd_mode_t m, input logic [15:0] a, input logic w, input logic [7:0] d);
		int k;
		k = 0;
		// Let an edge pass, so back-to-back calls never drop and raise valid at once
		@(negedge clk_sys_in);
		while (ready !== 1'b1 && k < 50)
		begin
			@(negedge clk_sys_in);
			k++;
		end
		n_wr = 8'h00;
		n_rd = 8'h00;
		n_oe = 8'h00;
		hp_ale = 8'h00;
		req_valid_in = 1'b1;
		req_mode_in = m;
		req_addr_in = a;
		req_write_in = w;
		req_wdata_in = d;
		@(negedge clk_sys_in);
		req_valid_in = 1'b0;
		got_region = region;
		got_rdata = 8'hEE;
		if (got_region == DMSD_REG_EXPANDED_ON_CHIP_RAM || got_region == DMSD_REG_EXT)
		begin
			k = 0;
			while (resp_valid !== 1'b1 && k < 20)
			begin
				@(negedge clk_sys_in);
				k++;
			end
			chk_byte({7'h00, resp_valid}, 8'h01);
			got_rdata = rdata;
		end
	endtask : do_req

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	// Internal pulses stand until the next rising edge, so they are read on return
	task automatic t_internal;
		do_req(DMSD_MODE_DIRECT, 16'h007F, 1'b1, 8'h11);
		chk_region(got_region, DMSD_REG_LOWER);
		chk_byte(int_addr, 8'h7F);
		chk_byte({7'h00, int_wr}, 8'h01);
		chk_byte(int_wdata, 8'h11);
		do_req(DMSD_MODE_INDIRECT, 16'h0000, 1'b0, 8'h00);
		chk_region(got_region, DMSD_REG_LOWER);
		chk_byte({7'h00, int_wr}, 8'h00);
		do_req(DMSD_MODE_DIRECT, 16'h0080, 1'b0, 8'h00);
		chk_region(got_region, DMSD_REG_SPECIAL);
		do_req(DMSD_MODE_INDIRECT, 16'h00A0, 1'b0, 8'h00);
		chk_region(got_region, DMSD_REG_UPPER);
		chk_byte(int_addr, 8'hA0);
		do_req(DMSD_MODE_DIRECT, 16'h00FF, 1'b0, 8'h00);
		chk_region(got_region, DMSD_REG_SPECIAL);
		do_req(DMSD_MODE_STACK, 16'h00FF, 1'b1, 8'h22);
		chk_region(got_region, DMSD_REG_UPPER);
		chk_byte(int_wdata, 8'h22);
		$display("test internal done");
	endtask : t_internal

	task automatic t_xram;
		sel_bit = 1'b0;
		large_var = 1'b0;
		do_req(DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_RI, 16'h00A0, 1'b1, 8'h5A);
		chk_region(got_region, DMSD_REG_EXPANDED_ON_CHIP_RAM);
		do_req(DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR, 16'h00A0, 1'b0, 8'h00);
		chk_byte(got_rdata, 8'h5A);
		chk_byte(n_wr + n_rd + n_oe, 8'h00);
		chk_byte(hp_out, hp_reg);
		large_var = 1'b1;
		do_req(DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR, 16'h02FF, 1'b1, 8'hA5);
		chk_region(got_region, DMSD_REG_EXPANDED_ON_CHIP_RAM);
		do_req(DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR, 16'h02FF, 1'b0, 8'h00);
		chk_byte(got_rdata, 8'hA5);
		$display("test expanded ram done");
	endtask : t_xram

	// Strobe counts come from the monitor, cleared at each request
	task automatic t_ext_clear;
		large_var = 1'b0;
		do_req(DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR, 16'h0100, 1'b1, 8'h3C);
		chk_region(got_region, DMSD_REG_EXT);
		chk_byte(hp_ale, 8'h01);
		chk_byte(n_wr, 8'(DMSD_STROBE_CYCLES));
		chk_byte(n_rd, 8'h00);
		chk_byte(got_rdata, 8'h00);
		do_req(DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR, 16'h0100, 1'b0, 8'h00);
		chk_byte(got_rdata, 8'h3C);
		chk_byte(n_rd, 8'(DMSD_STROBE_CYCLES));
		chk_byte(n_wr, 8'h00);
		large_var = 1'b1;
		do_req(DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR, 16'h0300, 1'b1, 8'h42);
		chk_region(got_region, DMSD_REG_EXT);
		chk_byte(hp_ale, 8'h03);
		large_var = 1'b0;
		$display("test ext clear done");
	endtask : t_ext_clear

	task automatic t_ext_set;
		sel_bit = 1'b1;
		do_req(DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_RI, 16'h0033, 1'b1, 8'h77);
		chk_region(got_region, DMSD_REG_EXT);
		chk_byte(hp_ale, hp_reg);
		do_req(DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_RI, 16'h0033, 1'b0, 8'h00);
		chk_byte(got_rdata, 8'h77);
		do_req(DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR, 16'h1234, 1'b1, 8'h96);
		chk_region(got_region, DMSD_REG_EXT);
		chk_byte(hp_ale, 8'h12);
		do_req(DMSD_MODE_EXTERNAL_MOVE_INSTRUCTION_DATA_POINTER_PAIR, 16'h1234, 1'b0, 8'h00);
		chk_byte(got_rdata, 8'h96);
		$display("test ext set done");
	endtask : t_ext_set

	task automatic complete_run;
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	// Watchdog: the tests need well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk_sys_in);
		n_errors++;
		complete_run();
	end

	initial
	begin
		repeat (8) @(negedge clk_sys_in);
		rst_in = 1'b0;
		repeat (2) @(negedge clk_sys_in);
		t_internal();
		t_xram();
		t_ext_clear();
		t_ext_set();
		complete_run();
	end
endmodule : testbench
